// ### hdl/cmp_hint_decoder.sv
// Decoder and executor for compares, processor-state change, copy alias and debug hint
// Operation
// - Negative compare adds shifted operand, carry zero
// - Flags from result; result never written
// - Second operand shifted with current carry
// - Short register forms apply no shift
// - Wide register forms decode type and amount
// - Wide register forms: bad first/second registers
// - Stack pointer allowed as first operand
// - Immediate compare adds inverse, carry one
// - Short immediate zero-extended, range 0-255
// - Wide immediate expanded; first PC unpredictable
// - Register compare adds inverse, carry one
// - First short form uses low registers
// - High-register form checks low pair, PC
// - Explicit shift only in wide form
// - State change sets or clears masks
// - State change refused inside conditional block
// - Copy alias decodes as register move
// - Debug hint is no-op with option
// - Debug option forwarded unchanged
`timescale 1ns/10ps
`include "cmpdec_consts.svh"
module cmp_hint_decoder (
	input  wire logic        clock,                 // 50 MHz core clock
	input  wire logic        rst,                   // Synchronous reset, high
	input  wire logic        instr_valid,           // Instruction presented this cycle
	input  wire logic [31:0] instr,                 // Instruction; short form in bits 15:0
	input  wire logic        wide_instr,            // High for a 32-bit encoding
	input  wire logic        cond_pass,             // Condition check passed
	input  wire logic        in_cond_block,         // Inside a conditional block
	input  wire logic [31:0] rn_value,              // Value of first operand register
	input  wire logic [31:0] rm_value,              // Value of second operand register
	output logic      [3:0]  first_operand_reg,     // Read index of first operand
	output logic      [3:0]  second_operand_reg,    // Read index of second operand
	output logic      [3:0]  app_status_flags,      // Flags N Z C V
	output logic             priority_mask_reg,     // Priority mask bit
	output logic             fault_escalation_mask, // Fault mask bit
	output logic             unpredictable,         // Pulse: operands unpredictable
	output logic             cond_block_reject,     // Pulse: state change refused
	output logic             flags_written,         // Pulse: compare updated flags
	output logic             debug_hint_valid,      // Pulse: debug hint executed
	output logic      [3:0]  debug_hint_option,     // Option of last debug hint
	output logic             register_move_valid,   // Pulse: move or copy decoded with condition passed
	output logic      [3:0]  move_dst,              // Move destination register
	output logic      [3:0]  move_src               // Move source register
);
	localparam cmpdec_pkg::state_t STATE_RST = '{
		nzcv: `FLAGS_RST, pmask: `PMASK_RST, fmask: `FMASK_RST,
		unpred: 1'h0, reject: 1'h0, dbg_vld: 1'h0, dbg_opt: 4'h0,
		mov_vld: 1'h0, mov_dst: 4'h0, mov_src: 4'h0, flag_wr: 1'h0};

	cmpdec_pkg::state_t      state_ff;
	cmpdec_pkg::state_t      nxt_state;
	cmpdec_pkg::op_kind_t    op;
	cmpdec_pkg::shift_kind_t skind;
	logic [5:0]              samt;
	logic [15:0]             hw1;
	logic [15:0]             hw2;
	logic [3:0]              rn;
	logic [3:0]              rm;
	logic                    use_imm;
	logic [31:0]             imm;
	logic                    bad;
	logic [32:0]             exp_imm;
	logic [8:0]              shd;
	logic [31:0]             opb;
	logic [31:0]             opb_inv;
	logic                    cin;
	logic [32:0]             sum;
	logic                    ovf;

	shift_if sh ();

	operand_shifter u_shift (
		.sh (sh.unit)
	);

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	// Immediate shift field to kind and amount; zero means 32 for LSR/ASR, RRX for ROR
	function automatic logic [8:0] imm_shift(input logic [1:0] t, input logic [4:0] a);
		logic [5:0] n;
		logic [2:0] k;
		n = {1'h0, a};
		k = cmpdec_pkg::SH_LSL;
		case (t)
			2'h0: k = cmpdec_pkg::SH_LSL;
			2'h1: begin
				k = cmpdec_pkg::SH_LSR;
				if (a == 5'h00) n = `FULL_SHIFT;
			end
			2'h2: begin
				k = cmpdec_pkg::SH_ASR;
				if (a == 5'h00) n = `FULL_SHIFT;
			end
			default: begin
				k = cmpdec_pkg::SH_ROR;
				if (a == 5'h00) begin
					k = cmpdec_pkg::SH_RRX;
					n = `RRX_SHIFT;
				end
			end
		endcase
		return {k, n};
	endfunction : imm_shift

	// Split immediate to 32-bit constant; top bit flags a reserved form
	function automatic logic [32:0] expand(input logic [11:0] f);
		logic [7:0]  b;
		logic [31:0] v;
		logic [63:0] d;
		logic        z;
		b = f[7:0];
		z = 1'h0;
		d = {24'h00_0000, 1'h1, f[6:0], 24'h00_0000, 1'h1, f[6:0]} >> f[11:7];
		v = d[31:0];
		if (f[11:10] == 2'h0) begin
			case (f[9:8])
				2'h0:    v = {24'h00_0000, b};
				2'h1:    v = {8'h00, b, 8'h00, b};
				2'h2:    v = {b, 8'h00, b, 8'h00};
				default: v = {b, b, b, b};
			endcase
			z = (f[9:8] != 2'h0) && (b == 8'h00);
		end
		return {z, v};
	endfunction : expand

	// ----------------------------------------
	// Instruction decode
	// ----------------------------------------
	assign hw1     = instr[31:16];
	assign hw2     = instr[15:0];
	assign exp_imm = expand({hw1[10], hw2[14:12], hw2[7:0]});
	assign shd     = imm_shift(hw2[5:4], {hw2[14:12], hw2[7:6]});

	// Classify the instruction and pull out operands and checks
	always_comb begin
		op      = cmpdec_pkg::OP_NONE;
		rn      = 4'h0;
		rm      = 4'h0;
		skind   = cmpdec_pkg::SH_LSL;
		samt    = `NO_SHIFT;
		use_imm = 1'h0;
		imm     = 32'h0000_0000;
		bad     = 1'h0;
		if (!wide_instr) begin
			if (hw2[15:6] == `CMN_R16_PAT) begin
				op = cmpdec_pkg::OP_CMN;
				rn = {1'h0, hw2[2:0]};
				rm = {1'h0, hw2[5:3]};
			end else if (hw2[15:6] == `CMP_R16_PAT) begin
				op = cmpdec_pkg::OP_CMP;
				rn = {1'h0, hw2[2:0]};
				rm = {1'h0, hw2[5:3]};
			end else if (hw2[15:8] == `CMP_HI16_PAT) begin
				op  = cmpdec_pkg::OP_CMP;
				rn  = {hw2[7], hw2[2:0]};
				rm  = hw2[6:3];
				bad = ((rn < `LOW_REG_LIMIT) && (rm < `LOW_REG_LIMIT)) ||
					(rn == `REG_PC) || (rm == `REG_PC);
			end else if (hw2[15:11] == `CMP_I16_PAT) begin
				op      = cmpdec_pkg::OP_CMP;
				rn      = {1'h0, hw2[10:8]};
				use_imm = 1'h1;
				imm     = {24'h00_0000, hw2[7:0]};
			end else if (hw2[15:8] == `MOV_HI16_PAT) begin
				op = cmpdec_pkg::OP_MOVE;
			end else if (hw2[15:5] == `CPS_PAT) begin
				op = cmpdec_pkg::OP_CPS;
			end
		end else begin
			if (((hw1[15:4] == `CMN_R32_PAT) || (hw1[15:4] == `CMP_R32_PAT)) &&
				(hw2[11:8] == `ONES4)) begin
				op    = (hw1[15:4] == `CMN_R32_PAT) ? cmpdec_pkg::OP_CMN : cmpdec_pkg::OP_CMP;
				rn    = hw1[3:0];
				rm    = hw2[3:0];
				skind = cmpdec_pkg::shift_kind_t'(shd[8:6]);
				samt  = shd[5:0];
				bad   = (rn == `REG_PC) || (rm == `REG_SP) || (rm == `REG_PC);
			end else if ((hw1[15:11] == `IMM32_PAT) && !hw2[15] && (hw2[11:8] == `ONES4) &&
				((hw1[9:4] == `CMN_I32_OP) || (hw1[9:4] == `CMP_I32_OP))) begin
				op      = (hw1[9:4] == `CMN_I32_OP) ? cmpdec_pkg::OP_CMN : cmpdec_pkg::OP_CMP;
				rn      = hw1[3:0];
				use_imm = 1'h1;
				imm     = exp_imm[31:0];
				bad     = (rn == `REG_PC) || exp_imm[32];
			end else if ((hw1 == `DBG_HW1) && (hw2[15:14] == `DBG_HW2_HI) &&
				(hw2[7:4] == `ONES4)) begin
				op = cmpdec_pkg::OP_DBG;
			end
		end
	end

	assign first_operand_reg  = rn;
	assign second_operand_reg = rm;

	// ----------------------------------------
	// Shifter and adder
	// ----------------------------------------
	// Current carry flag feeds the shifter
	assign sh.value    = rm_value;
	assign sh.kind     = skind;
	assign sh.amount   = samt;
	assign sh.carry_in = state_ff.nzcv[1];

	// Subtract is add of the inverse with carry one
	assign opb     = use_imm ? imm : sh.result;
	assign opb_inv = (op == cmpdec_pkg::OP_CMP) ? ~opb : opb;
	assign cin     = (op == cmpdec_pkg::OP_CMP) ? `CIN_SUB : `CIN_ADD;
	assign sum     = {1'h0, rn_value} + {1'h0, opb_inv} + {32'h0000_0000, cin};
	assign ovf     = (rn_value[31] == opb_inv[31]) && (sum[31] != rn_value[31]);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	// Flags only, no destination write; pulses clear each cycle
	always_comb begin
		nxt_state         = state_ff;
		nxt_state.unpred  = 1'h0;
		nxt_state.reject  = 1'h0;
		nxt_state.dbg_vld = 1'h0;
		nxt_state.mov_vld = 1'h0;
		nxt_state.flag_wr = 1'h0;
		if (instr_valid) begin
			nxt_state.unpred = bad;
			case (op)
				cmpdec_pkg::OP_CMN, cmpdec_pkg::OP_CMP: begin
					if (cond_pass && !bad) begin
						nxt_state.nzcv    = {sum[`SIGN_BIT], (sum[31:0] == 32'h0000_0000),
							sum[32], ovf};
						nxt_state.flag_wr = 1'h1;
					end
				end
				cmpdec_pkg::OP_CPS: begin
					if (in_cond_block) begin
						nxt_state.reject = 1'h1;
					end else begin
						if (hw2[`CPS_SEL_PRI]) nxt_state.pmask = hw2[`CPS_EFFECT];
						if (hw2[`CPS_SEL_FLT]) nxt_state.fmask = hw2[`CPS_EFFECT];
					end
				end
				cmpdec_pkg::OP_MOVE: begin
					if (cond_pass) begin
						nxt_state.mov_vld = 1'h1;
						nxt_state.mov_dst = {hw2[7], hw2[2:0]};
						nxt_state.mov_src = hw2[6:3];
					end
				end
				cmpdec_pkg::OP_DBG: begin
					if (cond_pass) begin
						nxt_state.dbg_vld = 1'h1;
						nxt_state.dbg_opt = hw2[3:0];
					end
				end
				default: nxt_state.unpred = 1'h0;
			endcase
		end
	end

	// State register
	always_ff @(posedge clock) begin
		if (rst) begin
			state_ff <= STATE_RST;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign app_status_flags      = state_ff.nzcv;
	assign priority_mask_reg     = state_ff.pmask;
	assign fault_escalation_mask = state_ff.fmask;
	assign unpredictable         = state_ff.unpred;
	assign cond_block_reject     = state_ff.reject;
	assign flags_written         = state_ff.flag_wr;
	assign debug_hint_valid      = state_ff.dbg_vld;
	assign debug_hint_option     = state_ff.dbg_opt;
	assign register_move_valid   = state_ff.mov_vld;
	assign move_dst              = state_ff.mov_dst;
	assign move_src              = state_ff.mov_src;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	logic        go_cmp;
	logic        reg_form;
	logic [32:0] ref_add;
	logic [31:0] ref_res;

	assign go_cmp   = instr_valid && cond_pass && !bad &&
		((op == cmpdec_pkg::OP_CMN) || (op == cmpdec_pkg::OP_CMP));
	assign reg_form = !use_imm;
	assign ref_add  = {1'h0, rn_value} + {1'h0, sh.result};
	// Plain add or subtract, kept apart from the inverting adder
	assign ref_res  = (op == cmpdec_pkg::OP_CMP) ? (rn_value - opb) : (rn_value + opb);

	sequence s_cps_in_block;
		instr_valid && (op == cmpdec_pkg::OP_CPS) && in_cond_block;
	endsequence
	sequence s_refused;
		cond_block_reject && $stable(priority_mask_reg) && $stable(fault_escalation_mask);
	endsequence

	cmn_carry_a: assert property (
		go_cmp && reg_form && (op == cmpdec_pkg::OP_CMN) |=>
		app_status_flags[1] == $past(ref_add[32]))
		else $error("negative compare carry wrong");

	cmp_borrow_a: assert property (
		go_cmp && reg_form && (op == cmpdec_pkg::OP_CMP) |=>
		app_status_flags[1] == ($past(rn_value) >= $past(sh.result)))
		else $error("register compare carry wrong");

	imm_equal_a: assert property (
		go_cmp && use_imm && (op == cmpdec_pkg::OP_CMP) |=>
		app_status_flags[2] == ($past(rn_value) == $past(imm)) && flags_written)
		else $error("immediate compare zero flag wrong");

	sign_flag_a: assert property (
		go_cmp |=> (app_status_flags[3] == $past(ref_res[31])) &&
		(app_status_flags[2] == ($past(ref_res) == 32'h0000_0000)))
		else $error("negative or zero flag not from result");

	short_noshift_a: assert property (
		instr_valid && !wide_instr && reg_form && (op != cmpdec_pkg::OP_NONE) |->
		sh.result == rm_value)
		else $error("short register form shifted operand");

	short_imm_a: assert property (
		use_imm && !wide_instr |-> imm[31:8] == 24'h00_0000)
		else $error("short immediate exceeds eight bits");

	wide_unpred_a: assert property (
		instr_valid && wide_instr && reg_form && (op != cmpdec_pkg::OP_NONE) &&
		((rm == `REG_SP) || (rn == `REG_PC)) |=> unpredictable && !flags_written)
		else $error("wide register operands not flagged");

	cond_hold_a: assert property (
		instr_valid && !cond_pass && (op != cmpdec_pkg::OP_CPS) |=>
		$stable(app_status_flags) && !debug_hint_valid && !flags_written)
		else $error("state changed with failed condition");

	cps_refuse_a: assert property (
		s_cps_in_block |=> s_refused)
		else $error("state change inside block not refused");

	dbg_forward_a: assert property (
		instr_valid && cond_pass && (op == cmpdec_pkg::OP_DBG) |=>
		debug_hint_valid && (debug_hint_option == $past(instr[3:0])) && $stable(app_status_flags))
		else $error("debug option not forwarded");
endmodule : cmp_hint_decoder

// ### hdl/cmpdec_consts.svh
// Encoding patterns, field positions, reset values and timing for the compare and hint decoder
`ifndef CMPDEC_CONSTS_SVH
`define CMPDEC_CONSTS_SVH
// 16-bit opcode patterns
`define CMN_R16_PAT   10'h10b
`define CMP_R16_PAT   10'h10a
`define CMP_HI16_PAT  8'h45
`define CMP_I16_PAT   5'h05
`define MOV_HI16_PAT  8'h46
`define CPS_PAT       11'h5b3
// 32-bit opcode patterns
`define CMN_R32_PAT   12'heb1
`define CMP_R32_PAT   12'hebb
`define IMM32_PAT     5'h1e
`define CMN_I32_OP    6'h11
`define CMP_I32_OP    6'h1b
`define DBG_HW1       16'hf3af
`define DBG_HW2_HI    2'h2
`define ONES4         4'hf
// Register numbers and field positions
`define REG_PC        4'hf
`define REG_SP        4'hd
`define LOW_REG_LIMIT 4'h8
`define SIGN_BIT      31
`define CPS_EFFECT    4
`define CPS_SEL_PRI   1
`define CPS_SEL_FLT   0
// Adder carry inputs and shift constants
`define CIN_ADD       1'h0
`define CIN_SUB       1'h1
`define NO_SHIFT      6'h00
`define FULL_SHIFT    6'h20
`define RRX_SHIFT     6'h01
// Reset values
`define FLAGS_RST     4'h0
`define PMASK_RST     1'h0
`define FMASK_RST     1'h0
// Results appear one clock after the instruction is presented
`define RESULT_LAT    1
`endif

// ### hdl/cmpdec_pkg.sv
// Types shared by the compare and hint decoder and its operand shifter
package cmpdec_pkg;
	// Shift kinds after immediate-shift decode
	typedef enum logic [2:0] {
		SH_LSL = 3'h0,
		SH_LSR = 3'h1,
		SH_ASR = 3'h2,
		SH_ROR = 3'h3,
		SH_RRX = 3'h4
	} shift_kind_t;
	// Instruction classes handled here
	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_CMN  = 3'h1,
		OP_CMP  = 3'h2,
		OP_CPS  = 3'h3,
		OP_MOVE = 3'h4,
		OP_DBG  = 3'h5
	} op_kind_t;
	// Whole state of the decoder
	typedef struct packed {
		logic [3:0] nzcv;
		logic       pmask;
		logic       fmask;
		logic       unpred;
		logic       reject;
		logic       dbg_vld;
		logic [3:0] dbg_opt;
		logic       mov_vld;
		logic [3:0] mov_dst;
		logic [3:0] mov_src;
		logic       flag_wr;
	} state_t;
endpackage : cmpdec_pkg

// ### hdl/operand_shifter.sv
// Barrel shifter for the second compare operand
`timescale 1ns/10ps
`include "cmpdec_consts.svh"
module operand_shifter (
	shift_if.unit sh // Operand, shift request and result
);
	logic [63:0] wide;

	// ----------------------------------------
	// Shift datapath
	// ----------------------------------------
	// Zero amount passes the value and carry through untouched
	always_comb begin
		wide         = 64'h0000_0000_0000_0000;
		sh.result    = sh.value;
		sh.carry_out = sh.carry_in;
		if (sh.amount != `NO_SHIFT) begin
			case (sh.kind)
				cmpdec_pkg::SH_LSL: begin
					wide         = {32'h0000_0000, sh.value} << sh.amount;
					sh.result    = wide[31:0];
					sh.carry_out = wide[32];
				end
				cmpdec_pkg::SH_LSR: begin
					wide         = {sh.value, 32'h0000_0000} >> sh.amount;
					sh.result    = wide[63:32];
					sh.carry_out = wide[31];
				end
				cmpdec_pkg::SH_ASR: begin
					wide         = 64'($signed({sh.value, 32'h0000_0000}) >>> sh.amount);
					sh.result    = wide[63:32];
					sh.carry_out = wide[31];
				end
				cmpdec_pkg::SH_ROR: begin
					wide         = {sh.value, sh.value} >> sh.amount[4:0];
					sh.result    = wide[31:0];
					sh.carry_out = wide[31];
				end
				default: begin
					sh.result    = {sh.carry_in, sh.value[31:1]};
					sh.carry_out = sh.value[0];
				end
			endcase
		end
	end
endmodule : operand_shifter

// ### hdl/shift_if.sv
// Connection between the decoder and its operand shifter
`timescale 1ns/10ps
interface shift_if;
	logic [31:0]              value;
	cmpdec_pkg::shift_kind_t  kind;
	logic [5:0]               amount;
	logic                     carry_in;
	logic [31:0]              result;
	logic                     carry_out;
	modport user (output value, kind, amount, carry_in, input result, carry_out);
	modport unit (input value, kind, amount, carry_in, output result, carry_out);
endinterface : shift_if

// ### test/tb_cmp_hint_decoder.sv
// Self-checking bench for the compare and hint decoder
`timescale 1ns/10ps
module tb_cmp_hint_decoder;
	// ----------------------------------------
	// Stimulus, observed outputs and counters
	// ----------------------------------------
	localparam time DLY = 1ns;
	logic        clock         = 1'b0;
	logic        rst           = 1'b1;
	logic        instr_valid   = 1'b0;
	logic [31:0] instr         = 32'h0000_0000;
	logic        wide_instr    = 1'b0;
	logic        cond_pass     = 1'b1;
	logic        in_cond_block = 1'b0;
	logic [31:0] rn_value      = 32'h0000_0000;
	logic [31:0] rm_value      = 32'h0000_0000;
	logic [3:0]  first_operand_reg, second_operand_reg, app_status_flags, debug_hint_option, move_dst, move_src;
	logic        priority_mask_reg, fault_escalation_mask, unpredictable, cond_block_reject;
	logic        flags_written, debug_hint_valid, register_move_valid;
	logic [3:0]  exp_flags     = 4'h0;
	int          failures      = 0;
	int          check_count   = 0;

	// 50 MHz clock
	always #10ns clock = ~clock;

	// Device under test
	cmp_hint_decoder i_dut (
		.clock(clock), .rst(rst), .instr_valid(instr_valid), .instr(instr), .wide_instr(wide_instr),
		.cond_pass(cond_pass), .in_cond_block(in_cond_block), .rn_value(rn_value), .rm_value(rm_value),
		.first_operand_reg(first_operand_reg), .second_operand_reg(second_operand_reg),
		.app_status_flags(app_status_flags), .priority_mask_reg(priority_mask_reg),
		.fault_escalation_mask(fault_escalation_mask), .unpredictable(unpredictable),
		.cond_block_reject(cond_block_reject), .flags_written(flags_written),
		.debug_hint_valid(debug_hint_valid), .debug_hint_option(debug_hint_option),
		.register_move_valid(register_move_valid), .move_dst(move_dst), .move_src(move_src)
	);

	// ----------------------------------------
	// Reference models and shared tasks
	// ----------------------------------------
	// Adder giving N Z C V
	function automatic logic [3:0] awc(input logic [31:0] a, input logic [31:0] b, input logic ci);
		logic [32:0] s;
		s = {1'b0, a} + {1'b0, b} + {32'h0000_0000, ci};
		return {s[31], s[31:0] == 32'h0000_0000, s[32], (a[31] == b[31]) && (s[31] != a[31])};
	endfunction : awc

	// Immediate shift; amount zero selects the 32-bit forms for LSR/ASR and the extend form for ROR
	function automatic logic [31:0] shf(input logic [31:0] v, input logic [1:0] t, input logic [4:0] n, input logic c);
		case (t)
			2'h0: return v << n;
			2'h1: return (n == 5'h00) ? 32'h0000_0000 : v >> n;
			2'h2: return (n == 5'h00) ? {32{v[31]}} : 32'($signed(v) >>> n);
			default: return (n == 5'h00) ? {c, v[31:1]} : (v >> n) | (v << (6'h20 - {1'b0, n}));
		endcase
	endfunction : shf

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Present one instruction and let its edge pass
	task automatic issue(input logic [31:0] ins, input logic [31:0] a, input logic [31:0] b);
		instr = ins;
		wide_instr = (ins[31:16] != 16'h0000);
		rn_value = a;
		rm_value = b;
		instr_valid = 1'b1;
		@(posedge clock);
		#DLY;
	endtask : issue

	// Pulses in order: unpredictable, reject, flags, hint, move
	task automatic pulses(input logic [4:0] exp);
		check({unpredictable, cond_block_reject, flags_written, debug_hint_valid, register_move_valid}, exp);
	endtask : pulses

	// Compare; opnd is the second operand after shift or expansion
	task automatic do_cmp(input logic [31:0] ins, input logic [31:0] a, input logic [31:0] m,
		input logic [31:0] opnd, input logic sub, input logic ok);
		if (ok)
			exp_flags = sub ? awc(a, ~opnd, 1'b1) : awc(a, opnd, 1'b0);
		issue(ins, a, m);
		check(app_status_flags, exp_flags);
		check({unpredictable, flags_written}, {!ok, ok});
	endtask : do_cmp

	task automatic fin(input string name);
		instr_valid = 1'b0;
		@(posedge clock);
		#DLY;
		$display("test %s done", name);
	endtask : fin

	task automatic chk_rst();
		check({app_status_flags, priority_mask_reg, fault_escalation_mask, debug_hint_option, move_dst, move_src}, 0);
		pulses(5'h00);
	endtask : chk_rst

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Short register forms, no shift, low registers only
	task automatic t_low16();
		do_cmp(32'h0000_4281, 32'h0000_0005, 32'h0000_0005, 32'h0000_0005, 1'b1, 1'b1);
		check({first_operand_reg, second_operand_reg}, 8'h10);
		do_cmp(32'h0000_42BA, 32'h8000_0000, 32'h0000_0001, 32'h0000_0001, 1'b1, 1'b1);
		check({first_operand_reg, second_operand_reg}, 8'h27);
		do_cmp(32'h0000_42C3, 32'hFFFF_FFFF, 32'h0000_0001, 32'h0000_0001, 1'b0, 1'b1);
		do_cmp(32'h0000_42D5, 32'h7FFF_FFFF, 32'h8000_0001, 32'h8000_0001, 1'b0, 1'b1);
		fin("low16");
	endtask : t_low16

	// Immediate compares, short and expanded
	task automatic t_imm();
		do_cmp(32'h0000_2BFF, 32'h0000_00FF, 32'h0000_0000, 32'h0000_00FF, 1'b1, 1'b1);
		do_cmp(32'h0000_2880, 32'h0000_007F, 32'h0000_0000, 32'h0000_0080, 1'b1, 1'b1);
		do_cmp(32'hF5B4_0F00, 32'h0080_0000, 32'h0000_0000, 32'h0080_0000, 1'b1, 1'b1);
		do_cmp(32'hF1B4_1FAB, 32'h0000_0001, 32'h0000_0000, 32'h00AB_00AB, 1'b1, 1'b1);
		do_cmp(32'hF11D_0F01, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0001, 1'b0, 1'b1);
		do_cmp(32'hF1BF_0F05, 32'h0000_0005, 32'h0000_0000, 32'h0000_0005, 1'b1, 1'b0);
		fin("immediate");
	endtask : t_imm

	// Wide register forms: every shift type, carry fed back
	task automatic t_wide();
		logic [1:0]  t;
		logic [4:0]  n;
		logic [31:0] m;
		m = 32'h8000_0013;
		for (int k = 0; k < 8; k++) begin
			t = k[1:0];
			n = k[2] ? 5'h19 : 5'h00;
			do_cmp({k[0] ? 16'hEB11 : 16'hEBB1, 1'b0, n[4:2], 4'hF, n[1:0], t, 4'h2}, 32'h1234_5678, m,
				shf(m, t, n, exp_flags[1]), !k[0], 1'b1);
		end
		do_cmp(32'hEBBF_0F02, 32'h0000_0001, 32'h0000_0001, 32'h0000_0001, 1'b1, 1'b0);
		do_cmp(32'hEBB1_0F0D, 32'h0000_0001, 32'h0000_0001, 32'h0000_0001, 1'b1, 1'b0);
		do_cmp(32'hEB11_0F0F, 32'h0000_0001, 32'h0000_0001, 32'h0000_0001, 1'b0, 1'b0);
		do_cmp(32'hEBBD_0F02, 32'h0000_0010, 32'h0000_0020, 32'h0000_0020, 1'b1, 1'b1);
		do_cmp(32'hEBB1_0F02, 32'h0000_0005, 32'h0000_0005, 32'h0000_0005, 1'b1, 1'b1);
		do_cmp(32'hEB11_0F32, 32'h0000_0001, 32'h0000_0002,
			shf(32'h0000_0002, 2'h3, 5'h00, exp_flags[1]), 1'b0, 1'b1);
		fin("wide");
	endtask : t_wide

	// High-register short form
	task automatic t_hi16();
		do_cmp(32'h0000_4591, 32'h0000_0003, 32'h0000_0009, 32'h0000_0009, 1'b1, 1'b1);
		check({first_operand_reg, second_operand_reg}, 8'h92);
		do_cmp(32'h0000_451A, 32'h0000_0001, 32'h0000_0001, 32'h0000_0001, 1'b1, 1'b0);
		do_cmp(32'h0000_458F, 32'h0000_0001, 32'h0000_0001, 32'h0000_0001, 1'b1, 1'b0);
		do_cmp(32'h0000_4579, 32'h0000_0001, 32'h0000_0001, 32'h0000_0001, 1'b1, 1'b0);
		fin("high16");
	endtask : t_hi16

	// Mask set, refusal inside a conditional block, clear
	task automatic t_cps();
		logic [15:0] ins [4] = '{16'hB672, 16'hB671, 16'hB662, 16'hB663};
		logic [2:0]  exp [4] = '{3'h4, 3'h6, 3'h7, 3'h0};
		for (int k = 0; k < 4; k++) begin
			in_cond_block = (k == 2);
			issue({16'h0000, ins[k]}, 32'h0000_0000, 32'h0000_0000);
			check({priority_mask_reg, fault_escalation_mask, cond_block_reject}, exp[k]);
		end
		in_cond_block = 1'b0;
		fin("state change");
	endtask : t_cps

	// Every hint option, back to back
	task automatic t_dbg();
		for (int k = 0; k < 16; k++) begin
			issue({28'hF3A_F80F, k[3:0]}, 32'h0000_0000, 32'h0000_0000);
			check(debug_hint_option, k[3:0]);
			pulses(5'h02);
			check(app_status_flags, exp_flags);
		end
		fin("debug hint");
	endtask : t_dbg

	// Copy alias decodes as move
	task automatic t_move();
		issue(32'h0000_4689, 32'h0000_0000, 32'h0000_0000);
		check({register_move_valid, move_dst, move_src}, 9'h191);
		issue(32'h0000_46F8, 32'h0000_0000, 32'h0000_0000);
		check({register_move_valid, move_dst, move_src}, 9'h18F);
		check(app_status_flags, exp_flags);
		fin("move");
	endtask : t_move

	// Failed condition: nothing happens, state change still acts
	task automatic t_cond();
		cond_pass = 1'b0;
		issue(32'h0000_4281, 32'h0000_0001, 32'h0000_0002);
		check(app_status_flags, exp_flags);
		pulses(5'h00);
		issue(32'hF3AF_80F3, 32'h0000_0000, 32'h0000_0000);
		check({debug_hint_valid, debug_hint_option}, 5'h0F);
		issue(32'h0000_4689, 32'h0000_0000, 32'h0000_0000);
		pulses(5'h00);
		issue(32'h0000_B671, 32'h0000_0000, 32'h0000_0000);
		check({priority_mask_reg, fault_escalation_mask}, 2'h1);
		cond_pass = 1'b1;
		fin("condition");
	endtask : t_cond

	// ----------------------------------------
	// Sequence, watchdog and verdict
	// ----------------------------------------
	task automatic give_verdict();
		$display("comparisons %0d, mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : give_verdict

	// Main sequence, with a second reset after the last scenario
	initial begin
		repeat (16) @(posedge clock);
		#DLY;
		rst = 1'b0;
		chk_rst();
		t_low16();
		t_imm();
		t_wide();
		t_hi16();
		t_cps();
		t_dbg();
		t_move();
		t_cond();
		rst = 1'b1;
		@(posedge clock);
		#DLY;
		rst = 1'b0;
		exp_flags = 4'h0;
		chk_rst();
		give_verdict();
	end

	// Watchdog well beyond the expected run
	initial begin
		#100us;
		failures++;
		$display("mismatch at %0t: watchdog expired", $time);
		give_verdict();
	end
endmodule : tb_cmp_hint_decoder
